// ---- src/mlpp_defs.svh ----
`ifndef MLPP_DEFS_SVH
`define MLPP_DEFS_SVH

`define MLPP_OP_WREN        8'h06
`define MLPP_OP_DUAL        8'ha2
`define MLPP_OP_QUAD        8'h32
`define MLPP_OP_STATUS      8'h25

`define MLPP_OP_CLKS        6'h08
`define MLPP_ADDR_CLKS      6'h20
`define MLPP_DATA_CLK       6'h21

`define MLPP_PAGE_BYTES     9'h100
`define MLPP_BLK_MSB        21
`define MLPP_BLK_LSB        16

`define MLPP_CLK_PERIOD_NS  100
`define MLPP_PROG_TIME_NS   1000
`define MLPP_PROG_CYCLES \
    ((`MLPP_PROG_TIME_NS + `MLPP_CLK_PERIOD_NS - 1) / `MLPP_CLK_PERIOD_NS)

`endif

// ---- src/mlpp_pkg.sv ----
`default_nettype none

package mlpp_pkg;

    typedef enum logic [2:0] {
        MLPP_IDLE,
        MLPP_EVAL,
        MLPP_READ,
        MLPP_WRITE,
        MLPP_TIMER
    } mlpp_state_t;

    typedef logic [7:0] mlpp_byte_t;

endpackage

`default_nettype wire

// ---- src/mlpp_buf_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface mlpp_buf_if;
    logic       we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;

    modport writer (output we, waddr, wdata);
    modport reader (output raddr, input rdata);
    modport mem    (input we, waddr, wdata, raddr, output rdata);
endinterface

`default_nettype wire

// ---- src/mlpp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module mlpp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic meta;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

`default_nettype wire

// ---- src/mlpp_page_buf.sv ----
`timescale 1ns/1ps
`default_nettype none

module mlpp_page_buf (
    input  wire logic wclk,
    input  wire logic rclk,
    mlpp_buf_if.mem   bus
);
    logic [7:0] mem [256];

    // Written only inside a frame; read on every system clock, but used only after the frame has ended
    always_ff @(posedge wclk) begin
        if (bus.we) begin
            mem[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge rclk) begin
        bus.rdata <= mem[bus.raddr];
    end
endmodule

`default_nettype wire

// ---- src/mlpp_page_program.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mlpp_defs.svh"

module mlpp_page_program
    import mlpp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sck,
    input  wire logic        csN,
    input  wire logic        io0In,
    input  wire logic        io1In,
    input  wire logic        io2In,
    input  wire logic        io3In,
    output var  logic        io1Out,
    output var  logic        io1Oe,
    input  wire logic        quadEnableBit,
    input  wire logic [63:0] blockProtect,
    output var  logic        writeEnableLatch,
    output var  logic        deviceBusyFlag,
    output var  logic        arrayWe,
    output var  logic [23:0] arrayAddr,
    output var  logic [7:0]  arrayData
);

    mlpp_buf_if bufIf();

    mlpp_page_buf bufU (
        .wclk (sck),
        .rclk (clk),
        .bus  (bufIf.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the host's serial clock

    logic             started;
    logic             busyLink;
    logic [5:0]       clkCnt;
    mlpp_byte_t       opcode;
    logic [23:0]      startAddr;
    logic [2:0]       dataBits;
    logic [8:0]       byteCnt;
    logic [7:0]       byteIdx;
    mlpp_byte_t       shiftData;
    logic [5:0]       next_clkCnt;
    mlpp_byte_t       next_shift;
    logic [2:0]       next_bits;
    logic             linkQuad;
    logic             linkIsProg;
    logic             dataPhase;

    // The serial clock stops between frames, so the busy level crosses
    // over the first edges of each frame; data writes start much later.
    // Cleared on the first edge of each frame, so no stale level survives
    mlpp_sync #(.RST_VAL(1'b0)) busySyncU (
        .clk  (sck),
        .rst  (!started),
        .din  (deviceBusyFlag),
        .dout (busyLink)
    );

    always_comb begin
        if (!started) begin
            next_clkCnt = 6'h01;
        end else if (clkCnt == `MLPP_DATA_CLK) begin
            next_clkCnt = clkCnt;
        end else begin
            next_clkCnt = clkCnt + 6'h01;
        end
        linkQuad   = (opcode == `MLPP_OP_QUAD);
        linkIsProg = (opcode == `MLPP_OP_DUAL) || linkQuad;
        dataPhase  = started && linkIsProg && (next_clkCnt == `MLPP_DATA_CLK);
        if (linkQuad) begin
            next_shift = {shiftData[3:0], io3In, io2In, io1In, io0In};
            next_bits  = dataBits + 3'h4;
        end else begin
            next_shift = {shiftData[5:0], io1In, io0In};
            next_bits  = dataBits + 3'h2;
        end
    end

    // Frame start and status drive; the frame's own select ends them
    always_ff @(posedge sck or posedge csN) begin
        if (csN) begin
            started <= 1'b0;
            io1Oe   <= 1'b0;
            io1Out  <= 1'b0;
        end else begin
            started <= 1'b1;
            if (next_clkCnt == `MLPP_OP_CLKS &&
                {opcode[6:0], io0In} == `MLPP_OP_STATUS) begin
                io1Oe <= 1'b1;
            end
            io1Out <= busyLink;
        end
    end

    // Frame fields stay put after select rises, for the system side to read
    always_ff @(posedge sck) begin
        clkCnt <= next_clkCnt;
        if (next_clkCnt <= `MLPP_OP_CLKS) begin
            opcode <= {started ? opcode[6:0] : 7'h00, io0In};
        end else if (next_clkCnt <= `MLPP_ADDR_CLKS) begin
            startAddr <= {startAddr[22:0], io0In};
        end
        if (!started) begin
            dataBits <= 3'h0;
            byteCnt  <= 9'h000;
            byteIdx  <= 8'h00;
        end else if (dataPhase) begin
            shiftData <= next_shift;
            dataBits  <= next_bits;
            if (next_bits == 3'h0) begin
                byteIdx <= byteIdx + 8'h01;
                if (byteCnt != `MLPP_PAGE_BYTES) begin
                    byteCnt <= byteCnt + 9'h001;
                end
            end
        end
    end

    // Offset wraps in eight bits, so later bytes overwrite the oldest
    always_comb begin
        bufIf.we    = dataPhase && (next_bits == 3'h0) && !busyLink;
        bufIf.waddr = startAddr[7:0] + byteIdx;
        bufIf.wdata = next_shift;
    end

    ////////////////////////////////////////////////////////////////////////
    // System side

    logic        csSync;
    logic        csPrev;
    logic        csRise;
    mlpp_state_t state;
    logic [8:0]  progIdx;
    logic [8:0]  progCount;
    logic [23:0] progBase;
    logic [15:0] timer;
    logic        evWren;
    logic        evProg;
    logic        evDone;
    logic        evProt;
    logic        goProg;

    mlpp_sync #(.RST_VAL(1'b1)) csSyncU (
        .clk  (clk),
        .rst  (rst),
        .din  (csN),
        .dout (csSync)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            csPrev <= 1'b1;
        end else begin
            csPrev <= csSync;
        end
    end

    // Frame fields are quasi-static here: the host keeps select high long
    // enough for the evaluation to finish before the next frame.
    always_comb begin
        csRise = csSync && !csPrev;
        evWren = (opcode == `MLPP_OP_WREN) && (clkCnt == `MLPP_OP_CLKS);
        evProg = (clkCnt >= `MLPP_OP_CLKS) &&
                 ((opcode == `MLPP_OP_DUAL) ||
                  (opcode == `MLPP_OP_QUAD && quadEnableBit));
        evDone = (clkCnt == `MLPP_DATA_CLK) && (dataBits == 3'h0) &&
                 (byteCnt != 9'h000);
        evProt = blockProtect[startAddr[`MLPP_BLK_MSB:`MLPP_BLK_LSB]];
        goProg = !deviceBusyFlag && writeEnableLatch && evProg &&
                 evDone && !evProt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= MLPP_IDLE;
            progIdx   <= 9'h000;
            progCount <= 9'h000;
            progBase  <= 24'h000000;
            timer     <= 16'h0000;
        end else begin
            unique case (state)
                MLPP_IDLE: begin
                    if (csRise) begin
                        state <= MLPP_EVAL;
                    end
                end
                MLPP_EVAL: begin
                    progIdx   <= 9'h000;
                    progCount <= byteCnt;
                    progBase  <= startAddr;
                    state     <= goProg ? MLPP_READ : MLPP_IDLE;
                end
                MLPP_READ: begin
                    state <= MLPP_WRITE;
                end
                MLPP_WRITE: begin
                    progIdx <= progIdx + 9'h001;
                    if (progIdx + 9'h001 == progCount) begin
                        timer <= 16'(`MLPP_PROG_CYCLES);
                        state <= MLPP_TIMER;
                    end else begin
                        state <= MLPP_READ;
                    end
                end
                MLPP_TIMER: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001) begin
                        state <= MLPP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            writeEnableLatch <= 1'b0;
        end else if (state == MLPP_EVAL && !deviceBusyFlag) begin
            if (evWren) begin
                writeEnableLatch <= 1'b1;
            end else if (writeEnableLatch && evProg && (!evDone || evProt)) begin
                writeEnableLatch <= 1'b0;
            end
        end else if (state == MLPP_TIMER && timer == 16'h0001) begin
            writeEnableLatch <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            deviceBusyFlag <= 1'b0;
        end else if (state == MLPP_EVAL && goProg) begin
            deviceBusyFlag <= 1'b1;
        end else if (state == MLPP_TIMER && timer == 16'h0001) begin
            deviceBusyFlag <= 1'b0;
        end
    end

    // Only offsets that took data are written; the rest of the page is
    // never touched
    always_comb begin
        bufIf.raddr = progBase[7:0] + progIdx[7:0];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arrayWe   <= 1'b0;
            arrayAddr <= 24'h000000;
            arrayData <= 8'h00;
        end else begin
            arrayWe <= (state == MLPP_WRITE);
            if (state == MLPP_WRITE) begin
                arrayAddr <= {progBase[23:8], bufIf.raddr};
                arrayData <= bufIf.rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [8:0] wrCount;

    always_ff @(posedge clk) begin
        if (rst || state == MLPP_EVAL) begin
            wrCount <= 9'h000;
        end else if (arrayWe) begin
            wrCount <= wrCount + 9'h001;
        end
    end

    chk_abort_partial: assert property (@(posedge clk) disable iff (rst)
        state == MLPP_EVAL && !deviceBusyFlag && writeEnableLatch &&
        evProg && !evDone |=> !writeEnableLatch && !deviceBusyFlag)
        else $error("partial program frame not aborted");

    chk_protect_skip: assert property (@(posedge clk) disable iff (rst)
        state == MLPP_EVAL && !deviceBusyFlag && writeEnableLatch &&
        evProg && evDone && evProt
        |=> !writeEnableLatch ##1 state == MLPP_IDLE && !deviceBusyFlag)
        else $error("protected program not skipped");

    chk_busy_hold: assert property (@(posedge clk) disable iff (rst)
        $rose(deviceBusyFlag) |-> deviceBusyFlag [*8])
        else $error("busy flag dropped too early");

    chk_busy_ends: assert property (@(posedge clk) disable iff (rst)
        $rose(deviceBusyFlag) |-> ##[1:800] !deviceBusyFlag)
        else $error("busy flag never cleared");

    chk_wel_done: assert property (@(posedge clk) disable iff (rst)
        $fell(deviceBusyFlag) |-> !writeEnableLatch)
        else $error("latch still set after programming");

    chk_ignore_nowel: assert property (@(posedge clk) disable iff (rst)
        state == MLPP_EVAL && !writeEnableLatch |=> !deviceBusyFlag)
        else $error("program ran with latch clear");

    chk_page_wrap: assert property (@(posedge clk) disable iff (rst)
        arrayWe |-> arrayAddr[23:8] == progBase[23:8])
        else $error("write left its page");

    chk_write_count: assert property (@(posedge clk) disable iff (rst)
        state == MLPP_WRITE ##1 state == MLPP_TIMER
        |-> ##1 wrCount == progCount)
        else $error("byte count mismatch");

    chk_lane_turn: assert property (@(posedge sck) disable iff (csN)
        dataPhase |-> !io1Oe)
        else $error("io1 driven during data intake");

    chk_status_drive: assert property (@(posedge sck) disable iff (csN)
        io1Oe |-> opcode == `MLPP_OP_STATUS)
        else $error("io1 driven outside status command");

    chk_byte_cap: assert property (@(posedge sck) disable iff (csN)
        dataPhase |=> byteCnt <= `MLPP_PAGE_BYTES)
        else $error("byte count over page size");

    cov_dual_prog: cover property (@(posedge clk) disable iff (rst)
        state == MLPP_EVAL && goProg && opcode == `MLPP_OP_DUAL);
    cov_quad_prog: cover property (@(posedge clk) disable iff (rst)
        state == MLPP_EVAL && goProg && opcode == `MLPP_OP_QUAD);
    cov_abort: cover property (@(posedge clk) disable iff (rst)
        state == MLPP_EVAL && writeEnableLatch && evProg && !evDone);
    cov_status: cover property (@(posedge sck) disable iff (csN)
        io1Oe && io1Out);

endmodule

`default_nettype wire

// ---- tb/mlpp_spi_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module mlpp_spi_host (
    output var  logic sck,
    output var  logic csN,
    output var  logic io0,
    output var  logic io1,
    output var  logic io2,
    output var  logic io3,
    input  wire logic io1Out,
    input  wire logic io1Oe
);
    logic sawHigh;
    logic sawFall;
    logic watch;

    ////////////////////////////////////////////////////////////////////////
    // Serial clock idles low and stands still between frames
    initial begin
        sck = 1'b0;
        {io3, io2, io1, io0} = 4'h5;
        watch = 1'b0;
        // A definite rise after time zero clears the frame start and io1 status drive registers
        #1 csN = 1'b1;
    end

    function automatic logic [7:0] dataByte(input int n);
        return 8'h3c + n[7:0] + ((n >= 256) ? 8'h55 : 8'h00);
    endfunction

    task automatic clock(input logic [3:0] lanes);
        {io3, io2, io1, io0} = lanes;
        #15 sck = 1'b1;
        #14;
        // Sample late in the high phase, after the registered update
        if (watch && io1Oe === 1'b1 && io1Out === 1'b1) sawHigh = 1'b1;
        if (watch && io1Oe === 1'b1 && io1Out === 1'b0 && sawHigh)
            sawFall = 1'b1;
        #1 sck = 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, input logic [23:0] addr,
                         input int lanes, input int nBytes, input int extra);
        logic [7:0] b;
        sawHigh = 1'b0;
        sawFall = 1'b0;
        csN = 1'b0;
        for (int i = 7; i >= 0; i--) clock({3'b0, op[i]});
        watch = (op == 8'h25);
        if (lanes != 0) begin
            for (int i = 23; i >= 0; i--) clock({3'b0, addr[i]});
        end
        for (int n = 0; n < nBytes; n++) begin
            b = dataByte(n);
            if (lanes == 2) begin
                for (int k = 0; k < 4; k++)
                    clock({2'b0, b[7-2*k], b[6-2*k]});
            end else begin
                for (int k = 0; k < 2; k++) clock(b[7-4*k -: 4]);
            end
        end
        for (int i = 0; i < extra; i++) clock({3'b0, i[0]});
        csN = 1'b1;
        watch = 1'b0;
        // Released lines must not keep showing the last value
        {io3, io2, io1, io0} = ~{io3, io2, io1, io0};
        #1000;
    endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk;
    logic        rst;
    logic        sck;
    logic        csN;
    logic        io0In;
    logic        io1In;
    logic        io2In;
    logic        io3In;
    logic        hostIo1;
    logic        io1Out;
    logic        io1Oe;
    logic        quadEnableBit;
    logic [63:0] blockProtect;
    logic        writeEnableLatch;
    logic        deviceBusyFlag;
    logic        arrayWe;
    logic [23:0] arrayAddr;
    logic [7:0]  arrayData;
    logic [7:0]  mem[logic [23:0]];
    int          nWrites;
    int          nMismatch;
    int          nCompared;
    int          cycles;

    assign io1In = io1Oe ? io1Out : hostIo1;

    mlpp_page_program u_mlpp_page_program (
        .clk(clk), .rst(rst), .sck(sck), .csN(csN),
        .io0In(io0In), .io1In(io1In), .io2In(io2In), .io3In(io3In),
        .io1Out(io1Out), .io1Oe(io1Oe), .quadEnableBit(quadEnableBit),
        .blockProtect(blockProtect), .writeEnableLatch(writeEnableLatch),
        .deviceBusyFlag(deviceBusyFlag), .arrayWe(arrayWe),
        .arrayAddr(arrayAddr), .arrayData(arrayData)
    );

    mlpp_spi_host u_mlpp_spi_host (
        .sck(sck), .csN(csN), .io0(io0In), .io1(hostIo1), .io2(io2In),
        .io3(io3In), .io1Out(io1Out), .io1Oe(io1Oe)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (arrayWe === 1'b1) begin
            mem[arrayAddr] = arrayData;
            nWrites++;
        end
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            completeRun();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic clear();
        mem.delete();
        nWrites = 0;
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        repeat (8) @(posedge clk);
        while (deviceBusyFlag !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check("busy", deviceBusyFlag, 0);
    endtask

    task automatic wren();
        u_mlpp_spi_host.frame(8'h06, 24'h0, 0, 0, 0);
        check("wel set", writeEnableLatch, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic dualWrap();
        clear();
        wren();
        u_mlpp_spi_host.frame(8'ha2, 24'h0000fe, 2, 3, 0);
        u_mlpp_spi_host.frame(8'h25, 24'h0, 0, 0, 80);
        check("busy seen", u_mlpp_spi_host.sawHigh, 1);
        check("busy fall", u_mlpp_spi_host.sawFall, 1);
        waitIdle();
        check("fe", mem[24'h0000fe], u_mlpp_spi_host.dataByte(0));
        check("ff", mem[24'h0000ff], u_mlpp_spi_host.dataByte(1));
        check("00", mem[24'h000000], u_mlpp_spi_host.dataByte(2));
        check("writes", nWrites, 3);
        check("wel done", writeEnableLatch, 0);
    endtask

    task automatic quadOver();
        clear();
        wren();
        u_mlpp_spi_host.frame(8'h32, 24'h010045, 4, 257, 0);
        waitIdle();
        check("writes", nWrites, 256);
        check("45", mem[24'h010045], u_mlpp_spi_host.dataByte(256));
        check("46", mem[24'h010046], u_mlpp_spi_host.dataByte(1));
        check("44", mem[24'h010044], u_mlpp_spi_host.dataByte(255));
    endtask

    task automatic protect();
        @(posedge clk);
        blockProtect <= 64'h2;
        for (int i = 0; i < 2; i++) begin
            clear();
            wren();
            u_mlpp_spi_host.frame(i ? 8'h32 : 8'ha2, 24'h010000,
                                  i ? 4 : 2, 1, 0);
            waitIdle();
            check("writes", nWrites, 0);
            check("wel", writeEnableLatch, 0);
        end
        @(posedge clk);
        blockProtect <= 64'h0;
    endtask

    task automatic aborts();
        logic [7:0] ops[4] = '{8'ha2, 8'ha2, 8'h32, 8'h32};
        int         lanes[4] = '{2, 2, 0, 4};
        int         nb[4] = '{1, 0, 0, 1};
        int         ex[4] = '{2, 0, 10, 1};
        for (int i = 0; i < 4; i++) begin
            clear();
            wren();
            u_mlpp_spi_host.frame(ops[i], 24'h000020, lanes[i], nb[i], ex[i]);
            waitIdle();
            check("writes", nWrites, 0);
            check("wel", writeEnableLatch, 0);
        end
    endtask

    task automatic refuse();
        clear();
        u_mlpp_spi_host.frame(8'ha2, 24'h000010, 2, 1, 0);
        waitIdle();
        check("no wel", nWrites, 0);
        wren();
        @(posedge clk);
        quadEnableBit <= 1'b0;
        u_mlpp_spi_host.frame(8'h32, 24'h000010, 4, 1, 0);
        waitIdle();
        check("no qe", nWrites, 0);
        check("wel kept", writeEnableLatch, 1);
        @(posedge clk);
        quadEnableBit <= 1'b1;
    endtask

    task automatic completeRun();
        if (nMismatch == 0 && nCompared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        quadEnableBit = 1'b1;
        blockProtect = 64'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        dualWrap();
        quadOver();
        protect();
        aborts();
        refuse();
        completeRun();
    end
endmodule

`default_nettype wire
